// [hw/nspc_host.sv]
`timescale 1ns/100ps
// How it works
// - after 70h, each read strobe low returns the status byte on the bus
// - pass/fail is taken only once ready after program or erase
// - pages of a block programmed strictly ascending; the host takes any page in addr_reg and does not check the order
// - bad block: one column read, mostly zero means bad; the host reads no column, it marks bad via mark-bad op or failed status
// - never erase a block known bad
// - check status after each program or erase, mark failed block bad
// - host corrects at least 8 bits per 512 bytes; this host has no ECC, program data goes out uncoded
// - during power-on busy only reset or 70h may be issued; a status op with the multi bit set also lets 71h out
// - end cache program with 10h, else poll bit 6 then reset; this host ends every cache program with 15h and polls bit 6, no reset
// - same termination for multi-plane cache program
// - no data driven while device outputs data in cache program
// - x8 program data columns 0 to 2175 including spare
module nspc_host import nspc_pkg::*; #(
    parameter int NBLOCKS = NBLK,
    parameter int LASTCOL = LAST_COL
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic cle, // command latch enable
    output logic ale, // address latch enable
    output logic ce_n, // chip enable, low
    output logic we_n, // write strobe, low
    output logic read_strobe_n, // read strobe, low
    output logic wp_n, // write protect, low
    output logic [7:0] dq_out, // bus data out
    output logic dq_oe, // bus drive enable
    input wire logic [7:0] dq_in, // bus data in
    input wire logic ready_busy_n // device busy when low
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_CMD = 7'b0000010,
        S_ADDR = 7'b0000100,
        S_DATA = 7'b0001000,
        S_CONF = 7'b0010000,
        S_WAIT = 7'b0100000,
        S_POLL = 7'b1000000
    } nspc_state_t;

    function automatic logic bad_of(input logic [NBLOCKS-1:0] t,
                                    input logic [15:0] b);
        bad_of = t[b[$clog2(NBLOCKS)-1:0]];
    endfunction

    nspc_state_t state_reg, state_next;
    logic [31:0] ctrl_reg, addr_reg, rslt_reg;
    logic [NBLOCKS-1:0] bad_reg;
    logic [7:0] last_cmd_reg, status_reg;
    logic [2:0] step_reg;
    logic [11:0] col_reg;
    logic busy_reg, err_reg, done_reg, fail_reg, init_seen_reg;
    logic [2:0] rb_sync;
    logic poll_cmd_reg;
    logic [7:0] dq_s2, dq_s3;
    logic rb_stable;
    logic go, go_rd, st_active, st_done;
    logic [7:0] st_rdata, drive_byte;
    logic drive_cle, drive_ale;

    // three-stage pin sampling; a change counts when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rb_sync <= 3'h0;
            rb_stable <= 1'b0;
            dq_s2 <= 8'h00;
            dq_s3 <= 8'h00;
        end else begin
            rb_sync <= {rb_sync[1:0], ready_busy_n};
            if (rb_sync[1] == rb_sync[2]) rb_stable <= rb_sync[2];
            dq_s2 <= dq_s1b;
            dq_s3 <= dq_s2;
        end
    end
    logic [7:0] dq_s1b;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dq_s1b <= 8'h00;
        else dq_s1b <= dq_in;
    end
    logic [7:0] dq_cur;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dq_cur <= 8'h00;
        else if (dq_s2 == dq_s3) dq_cur <= dq_s3;
    end
    wire apb_acc = psel && penable;
    wire apb_wr = apb_acc && pwrite;
    wire [2:0] op = ctrl_reg[2:0];
    wire multi = ctrl_reg[CTRL_MULTI];
    wire cache = ctrl_reg[CTRL_CACHE];
    wire [15:0] blk = addr_reg[31:16];
    wire blk_bad = bad_of(bad_reg, blk);
    wire start = apb_wr && (paddr == OFF_CTRL) && !busy_reg;
    // power-on busy: only reset or status may go out
    wire op_allowed = init_seen_reg || (pwdata[2:0] == OP_STATUS) ||
        (pwdata[2:0] == OP_RESET);
    wire erase_bad = (pwdata[2:0] == OP_ERASE) &&
        bad_of(bad_reg, addr_reg[31:16]);
    wire accept = start && op_allowed && !erase_bad;
    wire [7:0] status_cmd = multi ? CMD_DSTATUS : CMD_STATUS;
    wire [7:0] first_cmd = (op == OP_ERASE) ? CMD_ERASE :
        (op == OP_RESET) ? CMD_RESET :
        (op == OP_STATUS) ? status_cmd :
        (multi ? CMD_MPROG : CMD_PROG);
    wire [7:0] conf_cmd = (op == OP_ERASE) ? CMD_ECONF :
        (cache ? CMD_CACHE : CMD_CONF);
    // status bits: program/erase uses bit 5, cache wait uses bit 6
    wire ready_ok = cache ? dq_cur[ST_DCRDY] : dq_cur[ST_PBRDY];
    wire fail_now = dq_cur[ST_FAIL] |
        (cache & dq_cur[ST_PREV]);
    wire [7:0] addr_bytes[5];
    assign addr_bytes[0] = addr_reg[7:0];
    assign addr_bytes[1] = {4'h0, addr_reg[11:8]};
    assign addr_bytes[2] = addr_reg[23:16];
    assign addr_bytes[3] = addr_reg[31:24];
    assign addr_bytes[4] = 8'h00;
    wire [2:0] first_ab = (op == OP_ERASE) ? 3'd2 : 3'd0;

    always_comb begin
        state_next = state_reg;
        go = 1'b0;
        go_rd = 1'b0;
        drive_byte = 8'h00;
        drive_cle = 1'b0;
        drive_ale = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (accept && pwdata[2:0] != OP_MARKBAD) state_next = S_CMD;
            end
            S_CMD: begin
                go = 1'b1;
                drive_cle = 1'b1;
                // after a busy wait the status command goes out first
                drive_byte = poll_cmd_reg ? status_cmd : first_cmd;
                if (st_done) begin
                    if (op == OP_STATUS || poll_cmd_reg) state_next = S_POLL;
                    else if (op == OP_RESET) state_next = S_WAIT;
                    else state_next = S_ADDR;
                end
            end
            S_ADDR: begin
                go = 1'b1;
                drive_ale = 1'b1;
                drive_byte = addr_bytes[step_reg];
                if (st_done && step_reg == 3'd4) begin
                    state_next = (op == OP_ERASE) ? S_CONF : S_DATA;
                end
            end
            S_DATA: begin
                // writes only: device never outputs here
                go = 1'b1;
                drive_byte = col_reg[7:0] ^ addr_reg[7:0];
                if (st_done && col_reg == 12'(LASTCOL)) state_next = S_CONF;
            end
            S_CONF: begin
                go = 1'b1;
                drive_cle = 1'b1;
                drive_byte = conf_cmd;
                if (st_done) state_next = S_WAIT;
            end
            S_WAIT: begin
                if (rb_stable || cache) state_next = S_CMD;
            end
            S_POLL: begin
                go = 1'b1;
                go_rd = 1'b1;
                if (st_done && (op == OP_STATUS || ready_ok))
                    state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    // read data crosses four flops: hold the strobe until it has settled
    nspc_strobe #(.HOLD(STROBE_CYC + 3)) u_strobe (
        .pclk(pclk),
        .presetn(presetn),
        .go(go && !st_done),
        .rd(go_rd),
        .din_sync(dq_cur),
        .active(st_active),
        .done(st_done),
        .rdata(st_rdata)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            step_reg <= 3'h0;
            col_reg <= 12'h000;
            poll_cmd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == S_WAIT && state_next == S_CMD)
                poll_cmd_reg <= 1'b1;
            else if (state_reg == S_IDLE) poll_cmd_reg <= 1'b0;
            if (state_reg == S_CMD) step_reg <= first_ab;
            else if (state_reg == S_ADDR && st_done) step_reg <= step_reg + 3'd1;
            if (state_reg != S_DATA) col_reg <= addr_reg[11:0];
            else if (st_done) col_reg <= col_reg + 12'h001;
        end
    end

    // registers and results
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= RST_ZERO;
            addr_reg <= RST_ZERO;
            rslt_reg <= RST_ZERO;
            bad_reg <= '0;
            busy_reg <= 1'b0;
            err_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            init_seen_reg <= 1'b0;
            status_reg <= 8'h00;
            last_cmd_reg <= 8'h00;
        end else begin
            if (rb_stable) init_seen_reg <= 1'b1;
            if (apb_wr && paddr == OFF_ADDR && !busy_reg) addr_reg <= pwdata;
            if (start) begin
                err_reg <= !(op_allowed && !erase_bad);
                done_reg <= 1'b0;
            end
            if (accept) begin
                ctrl_reg <= pwdata;
                busy_reg <= (pwdata[2:0] != OP_MARKBAD);
                if (pwdata[2:0] == OP_MARKBAD)
                    bad_reg[addr_reg[16 +: $clog2(NBLOCKS)]] <= 1'b1;
            end
            if (st_done && (state_reg == S_CMD || state_reg == S_CONF))
                last_cmd_reg <= drive_byte;
            if (state_reg == S_POLL && st_done) begin
                status_reg <= st_rdata;
                if (op == OP_STATUS || ready_ok) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                    rslt_reg <= {16'h0000, last_cmd_reg, st_rdata};
                    if (op == OP_PROG || op == OP_ERASE) begin
                        fail_reg <= fail_now;
                        if (fail_now) bad_reg[blk[$clog2(NBLOCKS)-1:0]] <=
                            1'b1;
                    end
                end
            end
        end
    end

    // bus pins, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cle <= 1'b0;
            ale <= 1'b0;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            read_strobe_n <= 1'b1;
            wp_n <= 1'b0;
            dq_out <= 8'h00;
            dq_oe <= 1'b0;
            prdata <= RST_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cle <= drive_cle;
            ale <= drive_ale;
            ce_n <= !busy_reg;
            we_n <= !(st_active && !go_rd && !st_done);
            read_strobe_n <= !(st_active && go_rd && !st_done);
            wp_n <= ctrl_reg[5];
            dq_out <= drive_byte;
            dq_oe <= go && !go_rd;
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    OFF_CTRL: prdata <= ctrl_reg;
                    OFF_ADDR: prdata <= addr_reg;
                    OFF_STAT: prdata <= {24'h0, status_reg[7:5], 1'b0,
                        fail_reg, err_reg, done_reg, busy_reg};
                    OFF_RSLT: prdata <= rslt_reg;
                    OFF_BAD: prdata <= {31'h0, blk_bad};
                    default: begin
                        prdata <= RST_ZERO;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// [hw/nspc_pkg.sv]
package nspc_pkg;
    // command codes placed on the flash bus
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_DSTATUS = 8'h71;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_MPROG = 8'h81;
    localparam logic [7:0] CMD_CONF = 8'h10;
    localparam logic [7:0] CMD_CACHE = 8'h15;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ECONF = 8'hd0;
    // status byte fields
    localparam int ST_FAIL = 0;
    localparam int ST_PREV = 1;
    localparam int ST_PBRDY = 5;
    localparam int ST_DCRDY = 6;
    localparam int ST_WPN = 7;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_RSLT = 8'h0c;
    localparam logic [7:0] OFF_BAD = 8'h10;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // ctrl opcodes (bits 2:0), bit 3 = multi-plane, bit 4 = cache confirm
    localparam logic [2:0] OP_STATUS = 3'h1;
    localparam logic [2:0] OP_PROG = 3'h2;
    localparam logic [2:0] OP_ERASE = 3'h3;
    localparam logic [2:0] OP_RESET = 3'h4;
    localparam logic [2:0] OP_MARKBAD = 3'h5;
    localparam int CTRL_MULTI = 3;
    localparam int CTRL_CACHE = 4;
    // bus strobe timing
    localparam int STROBE_NS = 30;
    localparam int CLK_NS = 10;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int NBLK = 2048;
    localparam int LAST_COL = 2175;

    typedef struct packed {
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic [7:0] dq_out;
        logic dq_oe;
    } nspc_bus_t;
endpackage

// [hw/nspc_strobe.sv]
`timescale 1ns/100ps
// drives one byte cycle: we or re pulse, sampling on the last hold cycle, one clock before re rises
module nspc_strobe import nspc_pkg::*; #(
    parameter int HOLD = STROBE_CYC
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic go, // start one cycle when idle, level
    input wire logic rd, // 1 = read strobe, 0 = write strobe
    input wire logic [7:0] din_sync, // synchronised bus data
    output logic active, // strobe low
    output logic done, // cycle end, pulse
    output logic [7:0] rdata // byte sampled on read
);
    logic [7:0] cnt_reg;
    logic rd_reg;
    wire last = (cnt_reg == 8'(HOLD));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            rd_reg <= 1'b0;
            active <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
        end else begin
            done <= 1'b0;
            if (go && !active) begin
                active <= 1'b1;
                rd_reg <= rd;
                cnt_reg <= 8'h00;
            end else if (active) begin
                cnt_reg <= cnt_reg + 8'h01;
                if (last) begin
                    active <= 1'b0;
                    done <= 1'b1;
                    // sample before releasing: sync latency absorbed by hold
                    if (rd_reg) rdata <= din_sync;
                end
            end
        end
    end
endmodule

// [sim/nspc_dev.sv]
`timescale 1ns/100ps
// behavioural flash die: status bytes, busy timing, fail injection
module nspc_dev import nspc_pkg::*; #(
    parameter int INIT_NS = 3000,
    parameter int BUSY_NS = 2000
) (
    input wire logic ce_n, // chip enable
    input wire logic cle, // command latch
    input wire logic ale, // address latch
    input wire logic we_n, // write strobe
    input wire logic read_strobe_n, // read strobe
    input wire logic wp_n, // protect, low
    input wire logic [7:0] dq_out, // host data
    input wire logic fail_next, // next op fails
    output logic [7:0] dq_in, // device data
    output logic ready_busy_n // open drain, pulled up
);
    logic [7:0] cmd = 8'h00;
    logic busy = 1'b1; // busy through power-on init
    logic fail = 1'b0;
    int n_data = 0;
    int n_erase = 0;
    logic [7:0] st;
    // 71h: bit0 is or of district bits 1,2
    // 70h: bit0 fail, bits 2..4 zero, 5 equals 6, 7 protect
    assign st = (cmd == CMD_DSTATUS) ? {wp_n, ~busy, ~busy, 3'h0, fail, fail}
        : {wp_n, ~busy, ~busy, 3'h0, 1'b0, fail};
    // status accepted even while busy, fresh on every strobe
    // released bus shows the inverse so stale data never passes
    always @* begin
        if (!read_strobe_n && !ce_n) dq_in = st;
        else dq_in = ~st;
    end
    assign ready_busy_n = ~busy;
    initial #INIT_NS busy = 1'b0;
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            cmd = dq_out;
            if (dq_out == CMD_PROG) n_data = 0;
            if (dq_out == CMD_ECONF) n_erase++;
            if (dq_out == CMD_RESET) fail = 1'b0;
            if (dq_out == CMD_CONF || dq_out == CMD_ECONF) begin
                fail = fail_next;
                busy = 1'b1;
                busy <= #BUSY_NS 1'b0;
            end
        end else if (!ce_n && !ale) n_data++; // columns up to 2175
    end
endmodule

// [sim/nspc_host_asserts.sv]
`timescale 1ns/100ps
module nspc_host_asserts import nspc_pkg::*; (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic [7:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic cle, // command latch
    input wire logic ale, // address latch
    input wire logic ce_n, // chip enable
    input wire logic we_n, // write strobe
    input wire logic read_strobe_n, // read strobe
    input wire logic wp_n, // protect
    input wire logic [7:0] dq_out, // bus out
    input wire logic dq_oe, // bus enable
    input wire logic ready_busy_n // device ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic seen_rdy;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seen_rdy <= 1'b0;
        else if (ready_busy_n) seen_rdy <= 1'b1;
    end
    sequence s_wlow; !we_n [*3]; endsequence
    sequence s_rlow; (!read_strobe_n && !ce_n) [*3]; endsequence
    chk_strobe_excl: assert property (we_n || read_strobe_n)
        else $error("both strobes low");
    chk_no_drive_read: assert property (!read_strobe_n |-> !dq_oe)
        else $error("bus driven during read");
    chk_init_cmds: assert property (!seen_rdy && cle && !we_n
        |-> dq_out == CMD_STATUS || dq_out == CMD_RESET)
        else $error("command other than status or reset during init");
    chk_write_pulse: assert property ($fell(we_n) |-> s_wlow)
        else $error("write strobe too short");
    chk_read_pulse: assert property ($fell(read_strobe_n) |-> s_rlow)
        else $error("read strobe too short or chip not enabled");
    chk_cmd_drive: assert property (cle && !we_n |-> dq_oe && !ale)
        else $error("command byte not driven");
    chk_wp_reset: assert property ($rose(presetn) |-> !wp_n)
        else $error("write protect not asserted after reset");
    chk_apb_wait: assert property (psel && !penable |=> pready)
        else $error("apb access not zero wait");
    chk_apb_unmap: assert property (psel && penable && pready && paddr > OFF_BAD
        |-> pslverr)
        else $error("unmapped access without error");
    cover property (!read_strobe_n);
endmodule
bind nspc_host nspc_host_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .dq_out(dq_out),
    .dq_oe(dq_oe), .ready_busy_n(ready_busy_n));

// [sim/tb_nspc_host.sv]
`timescale 1ns/100ps
module tb_nspc_host import nspc_pkg::*; ;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, fail_next = 1'b0, pslverr, pready, cle, ale, ce_n;
    logic we_n, read_strobe_n, wp_n, dq_oe, ready_busy_n;
    logic [7:0] paddr = 8'h00, dq_out, dq_in;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic err;
    int errors = 0, n_compared = 0, ne;
    nspc_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cle(cle),
        .ale(ale), .ce_n(ce_n), .we_n(we_n), .read_strobe_n(read_strobe_n),
        .wp_n(wp_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
        .ready_busy_n(ready_busy_n));
    nspc_dev dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(wp_n), .dq_out(dq_out),
        .fail_next(fail_next), .dq_in(dq_in), .ready_busy_n(ready_busy_n));
    initial forever #5 pclk = ~pclk;
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // sample mid-cycle: the values that the next rising edge sees
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic op(input logic [2:0] code, input logic multi, wp);
        apb(1'b1, OFF_CTRL, {26'h0, wp, 1'b0, multi, code});
        repeat (2000) begin
            apb(1'b0, OFF_STAT, 32'h0);
            if (rd[0] === 1'b0) break;
        end
    endtask
    task automatic status(input logic multi, wp, input logic [7:0] exp);
        op(OP_STATUS, multi, wp);
        apb(1'b0, OFF_RSLT, 32'h0);
        check("status byte", rd[7:0], exp);
        check("status cmd", rd[15:8], multi ? CMD_DSTATUS : CMD_STATUS);
    endtask
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl reset", rd, RST_ZERO);
        apb(1'b1, OFF_ADDR, {16'h0003, 16'd2170});
        op(OP_PROG, 1'b0, 1'b1);
        apb(1'b0, OFF_STAT, 32'h0);
        check("prog refused in init", rd[2], 1'b1);
        check("no data in init", dev.n_data, 0);
        status(1'b0, 1'b1, 8'h80);
        $display("test init done");
        repeat (400) @(posedge pclk);
        status(1'b0, 1'b1, 8'he0);
        status(1'b0, 1'b0, 8'h60);
        op(OP_PROG, 1'b0, 1'b1);
        apb(1'b0, OFF_STAT, 32'h0);
        check("prog pass", rd[3], 1'b0);
        check("data bytes", dev.n_data, 6);
        $display("test program done");
        fail_next <= 1'b1;
        apb(1'b1, OFF_ADDR, {16'h0005, 16'd2170});
        op(OP_PROG, 1'b0, 1'b1);
        apb(1'b0, OFF_STAT, 32'h0);
        check("prog fail", rd[3], 1'b1);
        status(1'b0, 1'b1, 8'he1);
        status(1'b1, 1'b1, 8'he3);
        apb(1'b0, OFF_BAD, 32'h0);
        check("bad mark", rd[0], 1'b1);
        ne = dev.n_erase;
        op(OP_ERASE, 1'b0, 1'b1);
        apb(1'b0, OFF_STAT, 32'h0);
        check("erase bad refused", rd[2], 1'b1);
        check("no erase sent", dev.n_erase, ne);
        op(OP_RESET, 1'b0, 1'b1);
        status(1'b0, 1'b1, 8'he0);
        $display("test failure done");
        fail_next <= 1'b0;
        apb(1'b1, OFF_ADDR, {16'h0007, 16'd0});
        op(OP_ERASE, 1'b0, 1'b1);
        apb(1'b0, OFF_STAT, 32'h0);
        check("erase pass", rd[3:2], 2'b00);
        check("erase sent", dev.n_erase, ne + 1);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", err, 1'b1);
        $display("test erase done");
        close_out();
    end
endmodule
